/* hdl/fadc_cfg.svh */
// constants of the flash converter digital back end: sizes, register map,
// field positions and reset values; included by package and modules.
// assumes a 32-bit apb with byte addresses and word aligned registers.
`ifndef FADC_CFG_SVH
`define FADC_CFG_SVH

`define FADC_COMPARATORS 256
`define FADC_COLUMNS 4
`define FADC_COL_INPUTS 64
`define FADC_COL_CNT_W 7
`define FADC_SUM_W 9
`define FADC_WORD_W 8
`define FADC_LOW_W 7
`define FADC_COL_FULL 7'h40

`define FADC_ADDR_W 12
`define FADC_ADDR_CTRL 12'h000
`define FADC_ADDR_PERIOD 12'h004
`define FADC_ADDR_STATUS 12'h008
`define FADC_ADDR_MASK 12'h00c
`define FADC_ADDR_DATA 12'h010
`define FADC_ADDR_COUNT 12'h014

`define FADC_CTRL_EN 0
`define FADC_CTRL_MSB_INV 1
`define FADC_CTRL_LOW_INV 2
`define FADC_CTRL_STB_POL 3
`define FADC_CTRL_W 4
`define FADC_CTRL_RST 4'h0

`define FADC_EVT_DONE 0
`define FADC_EVT_OVR 1
`define FADC_EVT_W 2

`define FADC_PERIOD_W 8
`define FADC_PERIOD_RST 8'h02
`define FADC_PERIOD_MIN 8'h02
`define FADC_COUNT_W 16

`endif

/* hdl/fadc_pkg.sv */
// types shared by the converter back end modules.
// assumes fadc_cfg.svh is on the include path.
`include "fadc_cfg.svh"

package fadc_pkg;
	typedef logic [`FADC_COL_CNT_W-1:0] fadc_colcnt_type;
	typedef logic [`FADC_WORD_W-1:0] fadc_word_type;
	typedef logic [`FADC_EVT_W-1:0] fadc_evt_type;
	typedef logic [`FADC_PERIOD_W-1:0] fadc_period_type;
endpackage

/* hdl/fadc_col_decoder.sv */
// one column decoder: counts the ones among its comparator decisions.
// assumes the caller latches the count; purely combinational.
`timescale 1ns/1ps
`include "fadc_cfg.svh"

module fadc_col_decoder
	import fadc_pkg::*;
#(
	parameter int INPUTS = `FADC_COL_INPUTS
)
(
	input wire logic [INPUTS-1:0] col_bits,
	output fadc_colcnt_type col_count
);

	// ones count
	// a single flipped decision moves a count by one, never by a
	// power of two as a priority encoder would on a bubble
	always_comb
	begin
		col_count = '0;
		for (int i = 0; i < INPUTS; i++)
		begin
			col_count = col_count + fadc_colcnt_type'(col_bits[i]);
		end
	end

endmodule // fadc_col_decoder

/* hdl/fadc_out_stage.sv */
// output inversion and output latches of the converter.
// assumes load is a one-cycle pulse on pclk; controls are registers.
`timescale 1ns/1ps
`include "fadc_cfg.svh"

module fadc_out_stage
	import fadc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire fadc_word_type raw_word,
	input wire logic raw_over,
	input wire logic msb_inv,
	input wire logic low_inv,
	output fadc_word_type word_ff,
	output logic over_ff
);

	fadc_word_type nxt_word;

	always_comb
	begin
		nxt_word = {raw_word[`FADC_WORD_W-1] ^ msb_inv,
			raw_word[`FADC_LOW_W-1:0] ^ {`FADC_LOW_W{low_inv}}};
		if (raw_over)
		begin
			nxt_word = '1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_ff <= '0;
			over_ff <= 1'b0;
		end
		else if (load)
		begin
			word_ff <= nxt_word;
			over_ff <= raw_over;
		end
	end

endmodule // fadc_out_stage

/* hdl/fadc_top.sv */
// top of the flash converter digital back end: pin synchroniser,
// thermometer capture, column decode, output stage, apb registers, irq.
// assumes the comparator pins are asynchronous to pclk and that software
// programs the sample period before setting the enable bit.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "fadc_cfg.svh"

module fadc_top
	import fadc_pkg::*;
#(
	parameter int COMPARATORS = `FADC_COMPARATORS,
	parameter int COLUMNS = `FADC_COLUMNS
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`FADC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [COMPARATORS-1:0] comparator_bits,
	output logic [`FADC_LOW_W-1:0] low_result_bits,
	output logic top_result_bit,
	output logic overrange_flag,
	output logic sample_valid_strobe,
	output logic irq
);

	localparam int COL_IN = COMPARATORS / COLUMNS;

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [COMPARATORS-1:0] comp_meta_ff;
	logic [COMPARATORS-1:0] comp_sync_ff;
	logic [COMPARATORS-1:0] therm_ff;
	fadc_colcnt_type col_count [COLUMNS];
	fadc_colcnt_type col_ff [COLUMNS];
	logic [`FADC_SUM_W-1:0] code_sum;
	fadc_word_type raw_word;
	logic raw_over;
	fadc_word_type word_out;
	logic over_out;

	logic [`FADC_CTRL_W-1:0] ctrl_ff;
	fadc_period_type period_ff;
	fadc_period_type rate_cnt_ff;
	fadc_evt_type status_ff;
	fadc_evt_type mask_ff;
	logic [`FADC_COUNT_W-1:0] count_ff;

	logic tick_capture;
	logic tick_decode_ff;
	logic tick_load_ff;
	logic tick_word_ff;
	logic strobe_ff;

	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic [31:0] rd_mux;
	fadc_evt_type evt_set;
	fadc_evt_type evt_clr;
	fadc_period_type nxt_period;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser

	// comparator decisions arrive from another timing domain; only the
	// second stage is read by logic, a split word is caught by the
	// ones counting below and costs at most one lsb
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			comp_meta_ff <= '0;
			comp_sync_ff <= '0;
		end
		else
		begin
			comp_meta_ff <= comparator_bits;
			comp_sync_ff <= comp_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample timing

	// one sample every period_ff cycles while enabled
	assign tick_capture = ctrl_ff[`FADC_CTRL_EN] &&
		(rate_cnt_ff == fadc_period_type'(0));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rate_cnt_ff <= '0;
		end
		else if (!ctrl_ff[`FADC_CTRL_EN])
		begin
			rate_cnt_ff <= '0;
		end
		else if (tick_capture)
		begin
			rate_cnt_ff <= period_ff - fadc_period_type'(1);
		end
		else
		begin
			rate_cnt_ff <= rate_cnt_ff - fadc_period_type'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_decode_ff <= 1'b0;
			tick_load_ff <= 1'b0;
			tick_word_ff <= 1'b0;
			strobe_ff <= 1'b0;
		end
		else
		begin
			tick_decode_ff <= tick_capture;
			tick_load_ff <= tick_decode_ff;
			tick_word_ff <= tick_load_ff;
			strobe_ff <= tick_word_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// thermometer capture and column decode

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			therm_ff <= '0;
		end
		else if (tick_capture)
		begin
			therm_ff <= comp_sync_ff;
		end
	end

	generate
		for (genvar c = 0; c < COLUMNS; c++)
		begin : g_col
			fadc_col_decoder #(
				.INPUTS(COL_IN)
			) u_dec (
				.col_bits(therm_ff[c*COL_IN +: COL_IN]),
				.col_count(col_count[c])
			);

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					col_ff[c] <= '0;
				end
				else if (tick_decode_ff)
				begin
					col_ff[c] <= col_count[c];
				end
			end
		end
	endgenerate

	// combine columns
	// the sum of full columns gives the upper two bits (the partial
	// column index) and the partial column's count the lower six
	always_comb
	begin
		code_sum = '0;
		for (int c = 0; c < COLUMNS; c++)
		begin
			code_sum = code_sum + `FADC_SUM_W'(col_ff[c]);
		end
	end

	// overrange detect
	// every comparator set is the one level beyond the eight-bit range
	assign raw_over = code_sum[`FADC_SUM_W-1];
	assign raw_word = code_sum[`FADC_WORD_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// output stage

	fadc_out_stage u_out (
		.pclk(pclk),
		.presetn(presetn),
		.load(tick_load_ff),
		.raw_word(raw_word),
		.raw_over(raw_over),
		.msb_inv(ctrl_ff[`FADC_CTRL_MSB_INV]),
		.low_inv(ctrl_ff[`FADC_CTRL_LOW_INV]),
		.word_ff(word_out),
		.over_ff(over_out)
	);

	assign low_result_bits = word_out[`FADC_LOW_W-1:0];
	assign top_result_bit = word_out[`FADC_WORD_W-1];
	assign overrange_flag = over_out;

	// edge after word
	// strobe leaves its idle level one cycle after the word changes, so a receiver
	// latching on it sees a full cycle of setup
	// receiver uses strobe
	assign sample_valid_strobe = strobe_ff ^ ctrl_ff[`FADC_CTRL_STB_POL];

	////////////////////////////////////////////////////////////////////////
	// apb slave

	// zero wait states: every access finishes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	always_comb
	begin
		addr_hit = 1'b1;
		rd_mux = '0;
		case (paddr)
			`FADC_ADDR_CTRL: rd_mux[`FADC_CTRL_W-1:0] = ctrl_ff;
			`FADC_ADDR_PERIOD: rd_mux[`FADC_PERIOD_W-1:0] = period_ff;
			`FADC_ADDR_STATUS: rd_mux[`FADC_EVT_W-1:0] = status_ff;
			`FADC_ADDR_MASK: rd_mux[`FADC_EVT_W-1:0] = mask_ff;
			`FADC_ADDR_DATA: rd_mux[`FADC_WORD_W:0] = {over_out, word_out};
			`FADC_ADDR_COUNT: rd_mux[`FADC_COUNT_W-1:0] = count_ff;
			default: addr_hit = 1'b0;
		endcase
	end

	assign prdata = rd_en ? rd_mux : 32'h0000_0000;
	assign pslverr = psel && penable && !addr_hit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff <= `FADC_CTRL_RST;
		end
		else if (wr_en && paddr == `FADC_ADDR_CTRL)
		begin
			ctrl_ff <= pwdata[`FADC_CTRL_W-1:0];
		end
	end

	// a period below the minimum would starve the strobe of its low phase
	always_comb
	begin
		nxt_period = pwdata[`FADC_PERIOD_W-1:0];
		if (nxt_period < `FADC_PERIOD_MIN)
		begin
			nxt_period = `FADC_PERIOD_MIN;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			period_ff <= `FADC_PERIOD_RST;
		end
		else if (wr_en && paddr == `FADC_ADDR_PERIOD)
		begin
			period_ff <= nxt_period;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_ff <= '0;
		end
		else if (wr_en && paddr == `FADC_ADDR_MASK)
		begin
			mask_ff <= pwdata[`FADC_EVT_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_ff <= '0;
		end
		else if (tick_load_ff)
		begin
			count_ff <= count_ff + `FADC_COUNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status

	always_comb
	begin
		evt_set = '0;
		evt_set[`FADC_EVT_DONE] = tick_load_ff;
		evt_set[`FADC_EVT_OVR] = tick_load_ff && raw_over;
		evt_clr = '0;
		if (wr_en && paddr == `FADC_ADDR_STATUS)
		begin
			evt_clr = pwdata[`FADC_EVT_W-1:0];
		end
	end

	// set beats a same-cycle write-one-to-clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_ff <= '0;
		end
		else
		begin
			status_ff <= (status_ff & ~evt_clr) | evt_set;
		end
	end

	assign irq = |(status_ff & mask_ff);

endmodule // fadc_top

/* sim/fadc_cap.sv */
// capture logic model: latches each output word on the ready strobe.
// assumes the polarity input mirrors the strobe polarity control bit.
`timescale 1ns/1ps
module fadc_cap
	import fadc_pkg::*;
(
	input wire logic sample_valid_strobe,
	input wire logic strobe_polarity_ctl,
	input wire fadc_word_type word_in,
	input wire logic over_in,
	output fadc_word_type cap_word,
	output logic cap_over
);
	always @(sample_valid_strobe)
		if (sample_valid_strobe ^ strobe_polarity_ctl)
		begin
			cap_word = word_in;
			cap_over = over_in;
		end
endmodule // fadc_cap

/* sim/fadc_chk.sv */
// port assertions of the converter back end.
// assumes it is bound into fadc_top; presetn resets it.
`timescale 1ns/1ps
module fadc_chk
	import fadc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [6:0] low_result_bits,
	input wire logic top_result_bit,
	input wire logic overrange_flag,
	input wire logic sample_valid_strobe,
	input wire logic irq
);
	logic acc;
	logic rd;
	fadc_word_type w;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign w = {top_result_bit, low_result_bits};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////
	ready_high_a: assert property (pready)
		else $error("pready low");
	unmapped_err_a: assert property (acc && paddr > 12'h014 |->
		pslverr && prdata == 32'h0) else $error("unmapped not refused");
	mapped_ok_a: assert property (acc && paddr <= 12'h014 &&
		paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped refused");
	idle_rdata_a: assert property (!rd |-> prdata == 32'h0)
		else $error("read data outside read");
	over_forces_a: assert property (overrange_flag |-> w == 8'hff)
		else $error("overrange word not all ones");
	word_hold_a: assert property ($changed(w) |=> $stable(w))
		else $error("word changed twice in a row");
	strobe_follow_a: assert property ($changed(w) |=>
		$changed(sample_valid_strobe)) else $error("no strobe after word");
	strobe_after_a: assert property ($changed(w) |->
		$stable(sample_valid_strobe)) else $error("strobe moved with word");
	mask_off_a: assert property (acc && pwrite && paddr == 12'h00c &&
		pwdata[1:0] == 2'h0 |=> !irq) else $error("irq with mask clear");
	data_upper_a: assert property (rd && paddr == 12'h010 |->
		prdata[31:9] == 23'h0) else $error("data upper bits set");
	cover property (overrange_flag);
	cover property ($rose(irq));
	cover property (acc && pslverr);
endmodule // fadc_chk
bind fadc_top fadc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.low_result_bits(low_result_bits), .top_result_bit(top_result_bit),
	.overrange_flag(overrange_flag), .irq(irq),
	.sample_valid_strobe(sample_valid_strobe));

/* sim/flash_adc_digital_backend_tb.sv */
// self-checking bench of the converter back end over apb.
// assumes zero wait apb and a sample every 8 cycles once enabled.
`timescale 1ns/1ps
module flash_adc_digital_backend_tb;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready, e;
	logic top_result_bit, overrange_flag, sample_valid_strobe, irq;
	logic pol_ctl, cap_over;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [255:0] comparator_bits;
	logic [6:0] low_result_bits;
	logic [7:0] cap_word;
	logic [8:0] n, x;
	logic [8:0] corner [6] = '{9'd0, 9'd1, 9'd127, 9'd128, 9'd255, 9'd256};
	int n_mismatch, comparisons, cycles, k;
	fadc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .comparator_bits(comparator_bits),
		.low_result_bits(low_result_bits), .irq(irq),
		.top_result_bit(top_result_bit), .overrange_flag(overrange_flag),
		.sample_valid_strobe(sample_valid_strobe));
	fadc_cap u_cap (.sample_valid_strobe(sample_valid_strobe),
		.strobe_polarity_ctl(pol_ctl), .over_in(overrange_flag),
		.word_in({top_result_bit, low_result_bits}),
		.cap_word(cap_word), .cap_over(cap_over));
////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] v, t);
		comparisons++;
		if (v !== t)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", s, t, v);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		// model polarity moves before the strobe does, so the flip
		// of the strobe level at the write is not taken as a capture
		if (w && a == 12'h000)
			pol_ctl <= d[3];
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] t);
		apb(1'b0, a, 32'h0);
		chk("rdata", r, t);
		chk("pslverr", e, a > 12'h014);
	endtask
	function automatic logic [8:0] exp_out(input logic [8:0] c, m, l);
		if (c == 9'd256)
			return 9'h1ff;
		return {1'b0, c[7] ^ m[0], c[6:0] ^ {7{l[0]}}};
	endfunction
	// bubble below the top of the code keeps the ones count
	function automatic logic [255:0] therm(input logic [8:0] c);
		logic [255:0] v;
		v = (c == 9'd256) ? '1 : (256'h1 << c) - 256'h1;
		if (c > 9'd1 && c < 9'd256)
			v[c - 9'd1] = 1'b0;
		if (c > 9'd1 && c < 9'd256)
			v[c] = 1'b1;
		return v;
	endfunction
	task automatic sample(input logic [8:0] c);
		@(posedge pclk);
		comparator_bits <= therm(c);
		repeat (40) @(posedge pclk);
	endtask
////////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			finish_test;
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, pol_ctl} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		comparator_bits = '0;
		void'($urandom(32'h27aaec64));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (k = 0; k < 7; k++)
			rdc(12'(4 * k), k == 1 ? 32'h2 : 32'h0);
		apb(1'b1, 12'h004, 32'h0);
		rdc(12'h004, 32'h2);
		apb(1'b1, 12'h004, 32'h8);
		for (k = 0; k < 18; k++)
		begin
			n = k < 6 ? corner[k] : 9'($urandom_range(256, 0));
			apb(1'b1, 12'h000, 32'(k % 4 * 2 + 1));
			sample(n);
			x = exp_out(n, 9'(k % 2), 9'(k / 2 % 2));
			chk("word", {overrange_flag, top_result_bit,
				low_result_bits}, x);
			chk("capture", {cap_over, cap_word}, x);
			rdc(12'h010, x);
		end
		apb(1'b1, 12'h00c, 32'h3);
		@(posedge pclk);
		chk("irq", irq, 1'b1);
		apb(1'b1, 12'h000, 32'h0);
		repeat (20) @(posedge pclk);
		chk("strobe idle", sample_valid_strobe, 1'b0);
		apb(1'b1, 12'h008, 32'h3);
		@(posedge pclk);
		chk("irq", irq, 1'b0);
		rdc(12'h008, 32'h0);
		apb(1'b1, 12'h00c, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
		sample(9'd256);
		chk("irq", irq, 1'b0);
		rdc(12'h008, 32'h3);
		apb(1'b1, 12'h000, 32'h8);
		sample(9'd5);
		chk("strobe idle", sample_valid_strobe, 1'b1);
		apb(1'b1, 12'h000, 32'h9);
		repeat (40) @(posedge pclk);
		apb(1'b1, 12'h000, 32'h8);
		repeat (20) @(posedge pclk);
		chk("capture", {cap_over, cap_word}, 9'd5);
		chk("strobe idle", sample_valid_strobe, 1'b1);
		finish_test;
	end
endmodule // flash_adc_digital_backend_tb
